/* File: core_xfer_consts.svh */
`ifndef CORE_XFER_CONSTS_SVH
`define CORE_XFER_CONSTS_SVH

// ****************************************************************
// Register map (low address byte)
// ****************************************************************
`define OFS_HALT_CTRL      8'h00
`define OFS_CORE_SEL       8'h04
`define OFS_CORE_DATA      8'h08

// ****************************************************************
// Halt control/status fields
// ****************************************************************
`define HCS_DBGEN_BIT      0
`define HCS_HALTREQ_BIT    1
`define HCS_READY_BIT      16
`define HCS_HALTED_BIT     17

// ****************************************************************
// Selector fields and target codes
// ****************************************************************
`define SEL_DIR_BIT        16
`define SEL_CODE_MSB       4
`define CODE_GPR_LAST      5'h0c
`define CODE_CUR_SP        5'h0d
`define CODE_LR            5'h0e
`define CODE_RESUME        5'h0f
`define CODE_PSR           5'h10
`define CODE_MSP           5'h11
`define CODE_PSP           5'h12
`define CODE_MASKS         5'h14

// ****************************************************************
// Register file word indices
// ****************************************************************
`define IDX_MSP            5'h0d
`define IDX_PSP            5'h0e
`define IDX_LR             5'h0f
`define IDX_PSR            5'h10
`define MEM_WORDS          32
`define CTRL_SPSEL_BIT     1

// ****************************************************************
// Reset values
// ****************************************************************
`define RESUME_RESET       31'h0000_0000
`define WORD_RESET         32'h0000_0000

`endif

/* File: core_xfer_pkg.sv */
`include "core_xfer_consts.svh"
`default_nettype none
package core_xfer_pkg;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [2:0] {
      XF_IDLE = 3'h1,
      XF_RUN  = 3'h2,
      XF_CAPT = 3'h4
   } xfer_state_t;

   typedef enum logic [1:0] {
      TK_NONE   = 2'h0,
      TK_MEM    = 2'h1,
      TK_RESUME = 2'h2,
      TK_MASKS  = 2'h3
   } target_kind_t;

   typedef struct packed {
      logic [14:0] rsvd_hi;
      logic        transfer_direction;
      logic [10:0] rsvd_mid;
      logic [4:0]  target_select_code;
   } sel_word_t;

   typedef struct packed {
      logic        bkpt;
      logic [31:0] event_pc;
      logic [31:0] next_pc;
   } debug_event_t;

endpackage : core_xfer_pkg
`default_nettype wire

/* File: pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
   // Clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic ce,
   // Pin and clean level
   input  wire logic pin,
   output logic      level
);
   logic ff1_q;
   logic ff2_q;
   logic ff3_q;
   logic level_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ff1_q <= 1'b0;
         ff2_q <= 1'b0;
         ff3_q <= 1'b0;
      end else if (ce) begin
         ff1_q <= pin;
         ff2_q <= ff1_q;
         ff3_q <= ff2_q;
      end
   end

   // A change counts only once the two later stages agree
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         level_q <= 1'b0;
      end else if (ce && (ff2_q == ff3_q)) begin
         level_q <= ff3_q;
      end
   end

   assign level = level_q;
endmodule : pin_sync
`default_nettype wire

/* File: core_reg_mem.sv */
`timescale 1ns/1ps
`default_nettype none
`include "core_xfer_consts.svh"
module core_reg_mem
   import core_xfer_pkg::*;
(
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   // Single port
   input  wire logic        en,
   input  wire logic        we,
   input  wire logic [4:0]  idx,
   input  wire logic [31:0] wdata,
   output logic [31:0]      rdata
);
   logic [31:0] mem_q [`MEM_WORDS];
   logic [31:0] rdata_q;

   // Storage has no reset: register contents are undefined after reset
   always_ff @(posedge hclk) begin
      if (ce && en && we) begin
         mem_q[idx] <= wdata;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_q <= `WORD_RESET;
      end else if (ce && en && !we) begin
         rdata_q <= mem_q[idx];
      end
   end

   assign rdata = rdata_q;
endmodule : core_reg_mem
`default_nettype wire

/* File: core_xfer.sv */
// Design decisions made here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "core_xfer_consts.svh"
module core_xfer
   import core_xfer_pkg::*;
(
   // Clock, reset, enable
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic         ce,
   // AHB-Lite slave
   input  wire logic         hsel,
   input  wire logic [31:0]  haddr,
   input  wire logic [1:0]   htrans,
   input  wire logic         hwrite,
   input  wire logic [2:0]   hsize,
   input  wire logic         hready,
   input  wire logic [31:0]  hwdata,
   output logic [31:0]       hrdata,
   output logic              hreadyout,
   output logic              hresp,
   // Core execution side
   input  wire logic         debug_event_valid,
   input  wire debug_event_t debug_event,
   input  wire logic [31:0]  core_next_pc,
   input  wire logic         core_drained,
   input  wire logic         core_we,
   input  wire logic [4:0]   core_idx,
   input  wire logic [31:0]  core_wdata,
   output logic [31:0]       core_rdata,
   output logic              core_halted,
   output logic              core_resume,
   output logic [31:0]       resume_pc,
   output logic [1:0]        control_bits,
   output logic              interrupt_mask_reg,
   // External halt request pin
   input  wire logic         ext_halt_pin
);
   // ****************************************************************
   // Decoding
   // ****************************************************************
   function automatic target_kind_t target_kind(input logic [4:0] code);
      target_kind_t k;
      k = TK_NONE;
      if (code <= `CODE_GPR_LAST) begin
         k = TK_MEM;
      end else begin
         case (code)
            `CODE_CUR_SP, `CODE_LR, `CODE_PSR, `CODE_MSP, `CODE_PSP: k = TK_MEM;
            `CODE_RESUME: k = TK_RESUME;
            `CODE_MASKS:  k = TK_MASKS;
            default:      k = TK_NONE;
         endcase
      end
      return k;
   endfunction : target_kind

   function automatic logic [4:0] mem_index(input logic [4:0] code, input logic spsel);
      logic [4:0] i;
      i = code;
      case (code)
         `CODE_CUR_SP: i = spsel ? `IDX_PSP : `IDX_MSP;
         `CODE_MSP:    i = `IDX_MSP;
         `CODE_PSP:    i = `IDX_PSP;
         `CODE_LR:     i = `IDX_LR;
         `CODE_PSR:    i = `IDX_PSR;
         default:      i = code;
      endcase
      return i;
   endfunction : mem_index

   // ****************************************************************
   // State
   // ****************************************************************
   xfer_state_t   xf_q;
   target_kind_t  kind;
   logic          wr_pend_q;
   logic [7:0]    wr_ofs_q;
   logic [31:0]   hrdata_q;
   logic          dbgen_q;
   logic          halt_req_q;
   logic          halted_q;
   logic          resume_pulse_q;
   logic          pend_valid_q;
   debug_event_t  pend_q;
   logic [31:1]   resume_q;
   logic          ready_q;
   logic          dir_q;
   logic [4:0]    code_q;
   logic [31:0]   data_q;
   logic [1:0]    ctrl_q;
   logic          interrupt_mask_reg_q;
   logic          ext_halt;
   logic          addr_ok;
   logic          hcs_wr;
   logic          sel_wr;
   logic          data_wr;
   logic          xf_start;
   logic          enter_halt;
   logic          leave_halt;
   logic          mem_en;
   logic          mem_we;
   logic [4:0]    mem_idx;
   logic [31:0]   mem_wdata;
   logic [31:0]   mem_rdata;
   logic [31:0]   masks_word;
   sel_word_t     sel_in;

   // ****************************************************************
   // Bus slave
   // ****************************************************************
   assign addr_ok = hsel && hready && htrans[1];
   // A read right behind a write waits one cycle so it sees the write
   assign hreadyout = !(wr_pend_q && hsel && htrans[1] && !hwrite);
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;
   assign hcs_wr    = wr_pend_q && (wr_ofs_q == `OFS_HALT_CTRL);
   assign sel_wr    = wr_pend_q && (wr_ofs_q == `OFS_CORE_SEL);
   assign data_wr   = wr_pend_q && (wr_ofs_q == `OFS_CORE_DATA);
   assign masks_word = {6'h00, ctrl_q, 16'h0000, 7'h00, interrupt_mask_reg_q};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_ofs_q  <= 8'h00;
      end else if (ce) begin
         wr_pend_q <= addr_ok && hwrite;
         if (addr_ok) begin
            wr_ofs_q <= haddr[7:0];
         end
      end
   end

   // Read data is fetched at the address phase and stands in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= `WORD_RESET;
      end else if (ce && addr_ok && !hwrite) begin
         case (haddr[7:0])
            `OFS_HALT_CTRL: begin
               hrdata_q                   <= `WORD_RESET;
               hrdata_q[`HCS_DBGEN_BIT]   <= dbgen_q;
               hrdata_q[`HCS_HALTREQ_BIT] <= halt_req_q;
               hrdata_q[`HCS_READY_BIT]   <= ready_q;
               hrdata_q[`HCS_HALTED_BIT]  <= halted_q;
            end
            `OFS_CORE_DATA: hrdata_q <= data_q;
            default:        hrdata_q <= `WORD_RESET;
         endcase
      end
   end

   // ****************************************************************
   // Halt entry and exit
   // ****************************************************************
   pin_sync u_halt_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ce      (ce),
      .pin     (ext_halt_pin),
      .level   (ext_halt)
   );

   assign enter_halt = !halted_q && dbgen_q && core_drained &&
                       (pend_valid_q || halt_req_q || ext_halt);
   assign leave_halt = halted_q && hcs_wr && (xf_q == XF_IDLE) &&
                       (!hwdata[`HCS_HALTREQ_BIT] || !hwdata[`HCS_DBGEN_BIT]);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dbgen_q    <= 1'b0;
         halt_req_q <= 1'b0;
      end else if (ce && hcs_wr) begin
         dbgen_q    <= hwdata[`HCS_DBGEN_BIT];
         halt_req_q <= hwdata[`HCS_HALTREQ_BIT];
      end
   end

   // An event waits here until the pipeline has drained
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_valid_q <= 1'b0;
         pend_q       <= '0;
      end else if (ce) begin
         if (enter_halt) begin
            pend_valid_q <= 1'b0;
         end else if (debug_event_valid && dbgen_q && !halted_q && !pend_valid_q) begin
            pend_valid_q <= 1'b1;
            pend_q       <= debug_event;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         halted_q       <= 1'b0;
         resume_pulse_q <= 1'b0;
      end else if (ce) begin
         resume_pulse_q <= leave_halt;
         if (enter_halt) begin
            halted_q <= 1'b1;
         end else if (leave_halt) begin
            halted_q <= 1'b0;
         end
      end
   end

   // Bit 0 is never stored, so it reads zero and cannot reach the thumb flag
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         resume_q <= `RESUME_RESET;
      end else if (ce) begin
         if (enter_halt) begin
            if (pend_valid_q && pend_q.bkpt) begin
               resume_q <= pend_q.event_pc[31:1];
            end else if (pend_valid_q) begin
               resume_q <= pend_q.next_pc[31:1];
            end else begin
               resume_q <= core_next_pc[31:1];
            end
         end else if (xf_q == XF_RUN && kind == TK_RESUME && dir_q) begin
            resume_q <= data_q[31:1];
         end
      end
   end

   assign core_halted = halted_q;
   assign core_resume = resume_pulse_q;
   assign resume_pc   = {resume_q, 1'b0};

   // ****************************************************************
   // Transfer engine
   // ****************************************************************
   assign sel_in   = sel_word_t'(hwdata);
   // Only the direction and code are kept; other selector bits fall away
   assign xf_start = sel_wr && halted_q && (xf_q == XF_IDLE);
   assign kind     = target_kind(code_q);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         xf_q    <= XF_IDLE;
         ready_q <= 1'b1;
         dir_q   <= 1'b0;
         code_q  <= 5'h00;
      end else if (ce) begin
         case (xf_q)
            XF_IDLE: begin
               if (xf_start) begin
                  xf_q    <= XF_RUN;
                  ready_q <= 1'b0;
                  dir_q   <= sel_in.transfer_direction;
                  code_q  <= sel_in.target_select_code;
               end
            end
            XF_RUN: begin
               if (kind == TK_MEM && !dir_q) begin
                  xf_q <= XF_CAPT;
               end else begin
                  xf_q    <= XF_IDLE;
                  ready_q <= 1'b1;
               end
            end
            XF_CAPT: begin
               xf_q    <= XF_IDLE;
               ready_q <= 1'b1;
            end
            default: begin
               xf_q    <= XF_IDLE;
               ready_q <= 1'b1;
            end
         endcase
      end
   end

   // The engine's own update wins over a bus write in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         data_q <= `WORD_RESET;
      end else if (ce) begin
         if (xf_q == XF_CAPT) begin
            data_q <= mem_rdata;
         end else if (xf_q == XF_RUN && !dir_q && kind == TK_RESUME) begin
            data_q <= resume_pc;
         end else if (xf_q == XF_RUN && !dir_q && kind == TK_MASKS) begin
            data_q <= masks_word;
         end else if (data_wr) begin
            data_q <= hwdata;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q    <= 2'h0;
         interrupt_mask_reg_q <= 1'b0;
      end else if (ce && xf_q == XF_RUN && kind == TK_MASKS && dir_q) begin
         ctrl_q    <= data_q[25:24];
         interrupt_mask_reg_q <= data_q[0];
      end
   end

   assign control_bits = ctrl_q;
   assign interrupt_mask_reg      = interrupt_mask_reg_q;

   // Core owns the register file while running, the engine while halted
   always_comb begin
      if (halted_q) begin
         mem_en    = (xf_q == XF_RUN) && (kind == TK_MEM);
         mem_we    = (xf_q == XF_RUN) && (kind == TK_MEM) && dir_q;
         mem_idx   = mem_index(code_q, ctrl_q[`CTRL_SPSEL_BIT]);
         mem_wdata = data_q;
      end else begin
         mem_en    = 1'b1;
         mem_we    = core_we;
         mem_idx   = core_idx;
         mem_wdata = core_wdata;
      end
   end

   core_reg_mem u_regs (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ce      (ce),
      .en      (mem_en),
      .we      (mem_we),
      .idx     (mem_idx),
      .wdata   (mem_wdata),
      .rdata   (mem_rdata)
   );

   assign core_rdata = mem_rdata;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn || !ce);

   sequence s_start_read;
      xf_start && !sel_in.transfer_direction;
   endsequence

   sequence s_start_write;
      xf_start && sel_in.transfer_direction;
   endsequence

   AST_SEL_CLEARS_READY: assert property (xf_start |=> !ready_q)
      else $error("selector write did not clear ready");
   AST_READY_RETURNS: assert property (xf_start |-> ##[1:3] ready_q)
      else $error("ready did not return after transfer");
   AST_WRITE_KEEPS_DATA: assert property (s_start_write ##1 !data_wr |=> $stable(data_q))
      else $error("write transfer altered the data word");
   AST_READ_NO_MEM_WRITE: assert property (s_start_read |=> !mem_we [*2])
      else $error("read transfer wrote the register file");
   AST_GPR_INDEX: assert property (xf_q == XF_RUN && code_q <= `CODE_GPR_LAST
                                   |-> mem_idx == code_q)
      else $error("general register index mismatch");
   AST_CUR_SP: assert property (xf_q == XF_RUN && code_q == `CODE_CUR_SP
                                |-> mem_idx == (ctrl_q[1] ? `IDX_PSP : `IDX_MSP))
      else $error("current stack pointer not selected");
   AST_RESERVED_NOP: assert property (xf_start && target_kind(sel_in.target_select_code)
                                      == TK_NONE |=> !mem_en ##1 ready_q)
      else $error("reserved code caused a transfer");
   AST_RESUME_BIT0: assert property (resume_pc[0] == 1'b0 &&
                                     !(xf_q == XF_RUN && kind == TK_RESUME && mem_we))
      else $error("resume address bit 0 set or status touched");
   AST_RESUME_BKPT: assert property (enter_halt && pend_valid_q && pend_q.bkpt
                                     |=> resume_pc == {$past(pend_q.event_pc[31:1]), 1'b0})
      else $error("breakpoint resume address wrong");
   AST_HALT_DRAINED: assert property ($rose(halted_q) |-> $past(core_drained))
      else $error("halted before pipeline drained");
   AST_RESUME_WRITE: assert property (xf_q == XF_RUN && kind == TK_RESUME && dir_q
                                      |=> resume_pc == {$past(data_q[31:1]), 1'b0})
      else $error("written resume address lost");
   AST_RUNNING_IGNORED: assert property (sel_wr && !halted_q |=> xf_q == XF_IDLE)
      else $error("selector acted while running");
   AST_PSR_FULL: assert property (mem_we && halted_q |-> mem_wdata == data_q)
      else $error("status write masked bits");
endmodule : core_xfer
`default_nettype wire

/* File: dbg_master.sv */
`timescale 1ns/1ps
`default_nettype none
`include "core_xfer_consts.svh"
module dbg_master (
   // Clock
   input  wire logic        hclk,
   // AHB-Lite master side
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // ********
   // Single word transfer, entered just after a rising edge
   // ********
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      r = hrdata;
      // Released data must not keep showing the last value; the address is
      // left alone because the next call may set it at this very edge
      hwdata <= ~d;
   endtask : xfer
   task automatic poll(output logic ok);
      logic [31:0] s;
      ok = 1'b0;
      for (int i = 0; i < 20 && !ok; i++) begin
         xfer(1'b0, `OFS_HALT_CTRL, 32'h0, s);
         ok = (s[`HCS_READY_BIT] === 1'b1);
      end
   endtask : poll
   task automatic reg_read(input logic [31:0] sel, output logic [31:0] r, output logic ok);
      xfer(1'b1, `OFS_CORE_SEL, sel, r);
      poll(ok);
      xfer(1'b0, `OFS_CORE_DATA, 32'h0, r);
   endtask : reg_read
   task automatic reg_write(input logic [31:0] sel, input logic [31:0] d, output logic ok);
      logic [31:0] r;
      xfer(1'b1, `OFS_CORE_DATA, d, r);
      xfer(1'b1, `OFS_CORE_SEL, sel, r);
      poll(ok);
   endtask : reg_write
endmodule : dbg_master
`default_nettype wire

/* File: core_xfer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "core_xfer_consts.svh"
module core_xfer_bench
   import core_xfer_pkg::*;
;
   logic         hclk = 1'b0;
   logic         hresetn = 1'b0;
   logic         hsel, hwrite, hreadyout, hresp, core_halted, core_resume, interrupt_mask_reg;
   logic [31:0]  haddr, hwdata, hrdata, resume_pc, core_rdata;
   logic [1:0]   htrans, control_bits;
   logic [2:0]   hsize;
   logic         ev_valid = 1'b0;
   logic         drained = 1'b0;
   logic         cwe = 1'b0;
   logic [4:0]   cidx = 5'h00;
   logic [31:0]  cwdata = 32'h0;
   debug_event_t ev = '0;
   int           fail_count = 0;
   int           compares = 0;

   always #2 hclk = ~hclk;

   core_xfer core_xfer_inst (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .debug_event_valid(ev_valid), .debug_event(ev), .core_next_pc(32'h0000_0200),
      .core_drained(drained), .core_we(cwe), .core_idx(cidx), .core_wdata(cwdata),
      .core_rdata(core_rdata), .core_halted(core_halted), .core_resume(core_resume),
      .resume_pc(resume_pc), .control_bits(control_bits), .interrupt_mask_reg(interrupt_mask_reg),
      .ext_halt_pin(1'b0));
   dbg_master dbg_master_inst (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata));

   // ********
   // Helpers
   // ********
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic wait_for(input string name, ref logic sig);
      int n;
      n = 0;
      while (sig !== 1'b1 && n < 50) begin
         @(posedge hclk);
         n++;
      end
      chk(name, 32'h1, {31'h0, sig});
   endtask : wait_for
   task automatic pulse_event(input logic bk, input logic [31:0] pc, input logic [31:0] nx);
      ev <= '{bkpt: bk, event_pc: pc, next_pc: nx};
      ev_valid <= 1'b1;
      @(posedge hclk);
      ev_valid <= 1'b0;
   endtask : pulse_event
   task automatic conclude();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude

   // ********
   // Tests
   // ********
   initial begin
      logic [31:0] r;
      logic        ok;
      logic [4:0]  rc [7] = '{`CODE_CUR_SP, `CODE_LR, `CODE_RESUME, `CODE_PSR, `CODE_MSP,
                              `CODE_PSP, `CODE_MASKS};
      logic [31:0] re [7] = '{32'h100d, 32'h100f, 32'h0100, 32'h1010, 32'h100d, 32'h100e,
                              32'h0};
      logic [4:0]  wc [5] = '{5'h03, `CODE_RESUME, `CODE_PSR, `CODE_MASKS, `CODE_MSP};
      logic [31:0] wd [5] = '{32'ha5a5_0003, 32'h2001, 32'hf9ff_0010, 32'h0300_0001,
                              32'h5555_aaa0};
      logic [31:0] we [5] = '{32'ha5a5_0003, 32'h2000, 32'hf9ff_0010, 32'h0300_0001,
                              32'h5555_aaa0};
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      dbg_master_inst.xfer(1'b0, `OFS_HALT_CTRL, 32'h0, r);
      chk("status", 32'h0001_0000, r);
      cwe <= 1'b1;
      for (int i = 0; i < 17; i++) begin
         cidx <= i[4:0];
         cwdata <= 32'h1000 + i;
         @(posedge hclk);
      end
      cwe <= 1'b0;
      cidx <= 5'h05;
      repeat (2) @(posedge hclk);
      chk("core_rdata", 32'h1005, core_rdata);
      dbg_master_inst.xfer(1'b1, `OFS_HALT_CTRL, 32'h1, r);
      // Selector access while running must be ignored
      dbg_master_inst.xfer(1'b1, `OFS_CORE_DATA, 32'h1111, r);
      dbg_master_inst.xfer(1'b1, `OFS_CORE_SEL, 32'h0001_0005, r);
      chk("hresp", 32'h0, {31'h0, hresp});
      pulse_event(1'b1, 32'h100, 32'h102);
      repeat (4) @(posedge hclk);
      chk("halted early", 32'h0, {31'h0, core_halted});
      drained <= 1'b1;
      wait_for("halted", core_halted);
      chk("resume_pc", 32'h100, resume_pc);
      // Reserved selector bits set on every access
      for (int i = 0; i < 13; i++) begin
         dbg_master_inst.reg_read(32'hfffe_ffe0 | i, r, ok);
         chk("gpr", 32'h1000 + i, r);
         chk("ready", 32'h1, {31'h0, ok});
      end
      for (int i = 0; i < 7; i++) begin
         dbg_master_inst.reg_read(32'hfffe_ffe0 | rc[i], r, ok);
         chk("special", re[i], r);
      end
      // Status write replaces the whole word, exception number bits included
      for (int i = 0; i < 5; i++) begin
         dbg_master_inst.reg_write(32'hffff_ffe0 | wc[i], wd[i], ok);
         dbg_master_inst.reg_read(32'hfffe_ffe0 | wc[i], r, ok);
         chk("written", we[i], r);
      end
      chk("control", 32'h3, {30'h0, control_bits});
      chk("interrupt_mask_reg", 32'h1, {31'h0, interrupt_mask_reg});
      dbg_master_inst.reg_read({27'h0, `CODE_CUR_SP}, r, ok);
      chk("cur sp", 32'h100e, r);
      dbg_master_inst.reg_write(32'h0001_0013, 32'hdead_0000, ok);
      chk("ready rsvd", 32'h1, {31'h0, ok});
      dbg_master_inst.reg_read(32'h0000_0003, r, ok);
      chk("gpr3", 32'ha5a5_0003, r);
      dbg_master_inst.xfer(1'b1, `OFS_HALT_CTRL, 32'h1, r);
      wait_for("resume", core_resume);
      chk("restart pc", 32'h2000, resume_pc);
      pulse_event(1'b0, 32'h300, 32'h304);
      wait_for("halted again", core_halted);
      dbg_master_inst.reg_read({27'h0, `CODE_RESUME}, r, ok);
      chk("resume next", 32'h304, r);
      // Halt request bit: resume at the core's next unexecuted instruction
      dbg_master_inst.xfer(1'b1, `OFS_HALT_CTRL, 32'h1, r);
      dbg_master_inst.xfer(1'b1, `OFS_HALT_CTRL, 32'h3, r);
      wait_for("halt request", core_halted);
      chk("halt request pc", 32'h200, resume_pc);
      conclude();
   end

   // The tests need a few hundred cycles; 30000 means a hang
   initial begin
      repeat (30000) @(posedge hclk);
      fail_count++;
      conclude();
   end
endmodule : core_xfer_bench
`default_nettype wire
